// >>> holdover_and_lock_detect_ctrl.sv
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "holdover_ctrl_defs.svh"
module holdover_and_lock_detect_ctrl
  import holdover_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] compareToggle,
  input wire logic [`ERR_W-1:0] phaseErrorLoop1,
  input wire logic [`ERR_W-1:0] phaseErrorLoop2,
  input wire logic [`DAC_W-1:0] tuneLevel,
  output logic loop1TuneOutputEnable,
  output logic dacDriveEnable,
  output logic [`DAC_W-1:0] dacValue,
  output logic lockStatusPin,
  output logic holdoverStatusPin,
  output logic loop1LockDetect,
  output logic loop2LockDetect,
  output logic holdoverActive
);

  // ---------------------------------------------------------------
  // Registers.
  // ---------------------------------------------------------------
  logic [1:0] holdoverMode;
  logic forceHoldover;
  logic manualDacEnable;
  logic trackEnable;
  logic tuneRailDetectEnable;
  logic loop1LockLossDetectOff;
  logic loop2RefDoublerEnable;
  logic [`DACDIV_W-1:0] dacClkDiv;
  logic [`DAC_W-1:0] manualDacValue;
  logic [`DAC_W-1:0] dacUpperTrip;
  logic [`DAC_W-1:0] dacLowerTrip;
  logic [`ERR_W-1:0] phaseWindow [2];
  logic [`CNT_W-1:0] lockCountTarget [2];
  logic [`DIV1_W-1:0] loop1RefDiv;
  logic [`DIV1_W-1:0] loop1FbDiv;
  logic [`DIV2R_W-1:0] loop2RefDiv;
  logic [`PRESC_W-1:0] loop2Prescaler;
  logic [`DIV2N_W-1:0] loop2FbDiv;
  logic [3:0] lockPinSelect;
  logic [3:0] holdoverPinSelect;

  logic [`DAC_W-1:0] trackedDac;
  logic dacLow;
  logic dacHigh;
  hoState_t hoState;
  logic loop2HeldLock;
  logic [1:0] rawLock;
  logic [1:0] cmpEvent;
  logic [`ERR_W-1:0] errSync [2];
  logic [`DAC_W-1:0] tuneSync;

  // ---------------------------------------------------------------
  // Pin synchronisers.
  // ---------------------------------------------------------------
  logic [1:0] toggleMeta;
  logic [1:0] toggleSync;
  logic [1:0] toggleLast;
  logic [`ERR_W-1:0] errMeta [2];
  logic [`DAC_W-1:0] tuneMeta;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      toggleMeta <= 2'h0;
      toggleSync <= 2'h0;
      toggleLast <= 2'h0;
      errMeta[0] <= 8'h00;
      errMeta[1] <= 8'h00;
      errSync[0] <= 8'h00;
      errSync[1] <= 8'h00;
      tuneMeta <= 10'h000;
      tuneSync <= 10'h000;
    end else begin
      toggleMeta <= compareToggle;
      toggleSync <= toggleMeta;
      toggleLast <= toggleSync;
      errMeta[0] <= phaseErrorLoop1;
      errMeta[1] <= phaseErrorLoop2;
      errSync[0] <= errMeta[0];
      errSync[1] <= errMeta[1];
      tuneMeta <= tuneLevel;
      tuneSync <= tuneMeta;
    end
  end

  assign cmpEvent = toggleSync ^ toggleLast;

  // ---------------------------------------------------------------
  // Lock detectors, one per loop.
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gLock
      logic [`CNT_W-1:0] lockCount;
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          lockCount <= 14'h0000;
          rawLock[g] <= 1'b0;
        end else if (cmpEvent[g]) begin
          if (errSync[g] < phaseWindow[g]) begin
            if (!rawLock[g]) begin
              if (lockCount + 14'h0001 >= lockCountTarget[g]) begin
                rawLock[g] <= 1'b1;
              end
              lockCount <= lockCount + 14'h0001;
            end
          end else begin
            lockCount <= 14'h0000;
            rawLock[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Tuning trip detection and tracked DAC.
  // ---------------------------------------------------------------
  logic [`DACDIV_W-1:0] dacDivCount;
  logic dacTick;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dacLow <= 1'b0;
      dacHigh <= 1'b0;
    end else begin
      dacLow <= tuneSync < dacLowerTrip;
      dacHigh <= tuneSync > dacUpperTrip;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dacDivCount <= 10'h000;
      dacTick <= 1'b0;
    end else begin
      dacTick <= 1'b0;
      if (cmpEvent[0]) begin
        if (dacDivCount + 10'h001 >= dacClkDiv) begin
          dacDivCount <= 10'h000;
          dacTick <= 1'b1;
        end else begin
          dacDivCount <= dacDivCount + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trackedDac <= `RST_MANDAC;
    end else if (dacTick && trackEnable && hoState == HO_IDLE) begin
      if (tuneSync > trackedDac) begin
        trackedDac <= trackedDac + 10'h001;
      end else if (tuneSync < trackedDac) begin
        trackedDac <= trackedDac - 10'h001;
      end
    end
  end

  // ---------------------------------------------------------------
  // Holdover state.
  // ---------------------------------------------------------------
  logic rawLock1Last;
  logic modeEnabled;
  logic enterLockLoss;
  logic enterRail;

  assign modeEnabled = holdoverMode == `MODE_ENABLED;
  assign enterLockLoss = modeEnabled && !loop1LockLossDetectOff && rawLock1Last && !rawLock[0];
  assign enterRail = modeEnabled && tuneRailDetectEnable && trackEnable && (dacHigh || dacLow);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rawLock1Last <= 1'b0;
    end else begin
      rawLock1Last <= rawLock[0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hoState <= HO_IDLE;
      loop2HeldLock <= 1'b0;
    end else begin
      case (hoState)
        HO_IDLE: begin
          if (forceHoldover || enterLockLoss || enterRail) begin
            hoState <= HO_ACTIVE;
            loop2HeldLock <= rawLock[1];
          end
        end
        HO_ACTIVE: begin
          if (forceHoldover) begin
            hoState <= HO_ACTIVE;
          end else if (!modeEnabled) begin
            hoState <= HO_IDLE;
          end else if (rawLock[0] && !enterRail) begin
            hoState <= HO_IDLE;
          end
        end
        default: hoState <= HO_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status pin selection.
  // ---------------------------------------------------------------
  function automatic logic pinLevel(input logic [3:0] sel, input logic l1, input logic l2,
                                    input logic ho, input logic lo, input logic hi);
    case (sel)
      PIN_STATIC_LOW: pinLevel = 1'b0;
      PIN_STATIC_HIGH: pinLevel = 1'b1;
      PIN_LOCK1: pinLevel = l1;
      PIN_LOCK2: pinLevel = l2;
      PIN_LOCK_BOTH: pinLevel = l1 && l2;
      PIN_HOLDOVER: pinLevel = ho;
      PIN_DAC_RAIL: pinLevel = lo || hi;
      PIN_DAC_LOW: pinLevel = lo;
      PIN_DAC_HIGH: pinLevel = hi;
      default: pinLevel = 1'b0;
    endcase
  endfunction

  logic next_lock1;
  logic next_lock2;
  logic next_holdover;

  assign next_holdover = hoState == HO_ACTIVE;
  assign next_lock1 = rawLock[0] && !next_holdover;
  assign next_lock2 = next_holdover ? (loop2HeldLock || rawLock[1]) : rawLock[1];

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      loop1TuneOutputEnable <= 1'b1;
      dacDriveEnable <= 1'b0;
      dacValue <= `RST_MANDAC;
      lockStatusPin <= 1'b0;
      holdoverStatusPin <= 1'b0;
      loop1LockDetect <= 1'b0;
      loop2LockDetect <= 1'b0;
      holdoverActive <= 1'b0;
    end else begin
      loop1TuneOutputEnable <= !next_holdover;
      dacDriveEnable <= next_holdover;
      dacValue <= manualDacEnable ? manualDacValue : trackedDac;
      loop1LockDetect <= next_lock1;
      loop2LockDetect <= next_lock2;
      holdoverActive <= next_holdover;
      lockStatusPin <= pinLevel(lockPinSelect, next_lock1, next_lock2, next_holdover,
                                dacLow, dacHigh);
      holdoverStatusPin <= pinLevel(holdoverPinSelect, next_lock1, next_lock2, next_holdover,
                                    dacLow, dacHigh);
    end
  end

  // ---------------------------------------------------------------
  // APB slave: no wait state, answer in the first access cycle.
  // ---------------------------------------------------------------
  logic setupPhase;
  logic writeDone;
  logic mapped;
  logic [31:0] readWord;

  assign setupPhase = psel && !penable;
  assign writeDone = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    mapped = 1'b1;
    readWord = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: readWord = {6'h00, dacClkDiv, 8'h00, loop2RefDoublerEnable,
                             loop1LockLossDetectOff, tuneRailDetectEnable, trackEnable,
                             manualDacEnable, forceHoldover, holdoverMode};
      `OFS_MANDAC: readWord = {22'h000000, manualDacValue};
      `OFS_TRIP: readWord = {6'h00, dacUpperTrip, 6'h00, dacLowerTrip};
      `OFS_LOCK1: readWord = {10'h000, lockCountTarget[0], phaseWindow[0]};
      `OFS_LOCK2: readWord = {10'h000, lockCountTarget[1], phaseWindow[1]};
      `OFS_DIV1: readWord = {2'h0, loop1FbDiv, 2'h0, loop1RefDiv};
      `OFS_DIV2R: readWord = {12'h000, loop2Prescaler, 4'h0, loop2RefDiv};
      `OFS_DIV2N: readWord = {14'h0000, loop2FbDiv};
      `OFS_PINSEL: readWord = {24'h000000, holdoverPinSelect, lockPinSelect};
      `OFS_STATUS: readWord = {26'h0000000, dacHigh, dacLow, rawLock, loop2LockDetect,
                               holdoverActive};
      `OFS_DACCNT: readWord = {22'h000000, trackEnable ? trackedDac : 10'h000};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !mapped;
      prdata <= (setupPhase && !pwrite) ? readWord : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      holdoverMode <= 2'(`RST_CTRL);
      forceHoldover <= 1'b0;
      manualDacEnable <= 1'b0;
      trackEnable <= 1'b0;
      tuneRailDetectEnable <= 1'b0;
      loop1LockLossDetectOff <= 1'b0;
      loop2RefDoublerEnable <= 1'b0;
      dacClkDiv <= 10'(`RST_CTRL >> `CTRL_DACDIV_LSB);
      manualDacValue <= `RST_MANDAC;
      dacUpperTrip <= `RST_TRIP_HI;
      dacLowerTrip <= `RST_TRIP_LO;
      phaseWindow[0] <= `RST_WINDOW;
      phaseWindow[1] <= `RST_WINDOW;
      lockCountTarget[0] <= `RST_TARGET;
      lockCountTarget[1] <= `RST_TARGET;
      loop1RefDiv <= `RST_DIV;
      loop1FbDiv <= `RST_DIV;
      loop2RefDiv <= 12'h001;
      loop2Prescaler <= `RST_PRESC;
      loop2FbDiv <= 18'h00001;
      lockPinSelect <= PIN_LOCK1;
      holdoverPinSelect <= PIN_HOLDOVER;
    end else if (writeDone) begin
      case (paddr)
        `OFS_CTRL: begin
          holdoverMode <= pwdata[`CTRL_MODE_LSB +: 2];
          forceHoldover <= pwdata[`CTRL_FORCE];
          manualDacEnable <= pwdata[`CTRL_MANDAC_EN];
          trackEnable <= pwdata[`CTRL_TRACK_EN];
          tuneRailDetectEnable <= pwdata[`CTRL_RAIL_EN];
          loop1LockLossDetectOff <= pwdata[`CTRL_LOCKLOSS_OFF];
          loop2RefDoublerEnable <= pwdata[`CTRL_DOUBLER_EN];
          dacClkDiv <= pwdata[`CTRL_DACDIV_LSB +: `DACDIV_W];
        end
        `OFS_MANDAC: manualDacValue <= pwdata[`DAC_W-1:0];
        `OFS_TRIP: begin
          dacLowerTrip <= pwdata[`DAC_W-1:0];
          dacUpperTrip <= pwdata[16 +: `DAC_W];
        end
        `OFS_LOCK1: begin
          phaseWindow[0] <= pwdata[`ERR_W-1:0];
          lockCountTarget[0] <= pwdata[8 +: `CNT_W];
        end
        `OFS_LOCK2: begin
          phaseWindow[1] <= pwdata[`ERR_W-1:0];
          lockCountTarget[1] <= pwdata[8 +: `CNT_W];
        end
        `OFS_DIV1: begin
          loop1RefDiv <= pwdata[`DIV1_W-1:0];
          loop1FbDiv <= pwdata[16 +: `DIV1_W];
        end
        `OFS_DIV2R: begin
          loop2RefDiv <= pwdata[`DIV2R_W-1:0];
          if (pwdata[16 +: `PRESC_W] >= `PRESC_MIN && pwdata[16 +: `PRESC_W] <= `PRESC_MAX) begin
            loop2Prescaler <= pwdata[16 +: `PRESC_W];
          end
        end
        `OFS_DIV2N: loop2FbDiv <= pwdata[`DIV2N_W-1:0];
        `OFS_PINSEL: begin
          lockPinSelect <= pwdata[3:0];
          holdoverPinSelect <= pwdata[7:4];
        end
        default: holdoverMode <= holdoverMode;
      endcase
    end
  end

endmodule

// >>> holdover_ctrl_defs.svh
`ifndef HOLDOVER_CTRL_DEFS_SVH
`define HOLDOVER_CTRL_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_MANDAC 8'h04
`define OFS_TRIP 8'h08
`define OFS_LOCK1 8'h0c
`define OFS_LOCK2 8'h10
`define OFS_DIV1 8'h14
`define OFS_DIV2R 8'h18
`define OFS_DIV2N 8'h1c
`define OFS_PINSEL 8'h20
`define OFS_STATUS 8'h24
`define OFS_DACCNT 8'h28

// ---------------------------------------------------------------
// Control register fields.
// ---------------------------------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_FORCE 2
`define CTRL_MANDAC_EN 3
`define CTRL_TRACK_EN 4
`define CTRL_RAIL_EN 5
`define CTRL_LOCKLOSS_OFF 6
`define CTRL_DOUBLER_EN 7
`define CTRL_DACDIV_LSB 16

// ---------------------------------------------------------------
// Field widths, limits and encodings.
// ---------------------------------------------------------------
`define DAC_W 10
`define ERR_W 8
`define CNT_W 14
`define DACDIV_W 10
`define DIV1_W 14
`define DIV2R_W 12
`define DIV2N_W 18
`define PRESC_W 4
`define PRESC_MIN 4'h2
`define PRESC_MAX 4'h8
`define MODE_DISABLED 2'h0
`define MODE_ENABLED 2'h2

// ---------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------
`define RST_CTRL 32'h0001_0000
`define RST_MANDAC 10'h200
`define RST_TRIP_HI 10'h3c0
`define RST_TRIP_LO 10'h040
`define RST_WINDOW 8'h10
`define RST_TARGET 14'h0400
`define RST_PRESC 4'h2
`define RST_DIV 14'h0001

`endif

// >>> holdover_ctrl_pkg.sv
package holdover_ctrl_pkg;

  typedef enum logic [3:0] {
    PIN_STATIC_LOW = 4'h0,
    PIN_STATIC_HIGH = 4'h1,
    PIN_LOCK1 = 4'h2,
    PIN_LOCK2 = 4'h3,
    PIN_LOCK_BOTH = 4'h4,
    PIN_HOLDOVER = 4'h5,
    PIN_DAC_RAIL = 4'h6,
    PIN_DAC_LOW = 4'h7,
    PIN_DAC_HIGH = 4'h8
  } pinSel_t;

  typedef enum logic {
    HO_IDLE,
    HO_ACTIVE
  } hoState_t;

endpackage

// >>> holdover_and_lock_detect_ctrl_checker.sv
`timescale 1ns/1ps
`include "holdover_ctrl_defs.svh"
module holdover_and_lock_detect_ctrl_checker
  import holdover_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic loop1TuneOutputEnable,
  input wire logic dacDriveEnable,
  input wire logic [`DAC_W-1:0] dacValue,
  input wire logic loop1LockDetect,
  input wire logic holdoverActive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire logic ctrlWr = psel && penable && pready && pwrite && paddr == `OFS_CTRL;
  property p_answer; psel && !penable |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("Ready missing in access cycle.");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("Ready held too long.");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("Error without ready.");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("Read data outside access.");
  property p_hiz; holdoverActive |-> !loop1TuneOutputEnable && dacDriveEnable; endproperty
  a_hiz: assert property (p_hiz) else $error("Tuning drive wrong in holdover.");
  property p_hide; holdoverActive && $past(holdoverActive) |-> !loop1LockDetect; endproperty
  a_hide: assert property (p_hide) else $error("Lock shown in holdover.");
  property p_force; ctrlWr && pwdata[`CTRL_FORCE] |-> ##[1:4] holdoverActive; endproperty
  a_force: assert property (p_force) else $error("Force did not enter holdover.");
  property p_leave;
    ctrlWr && pwdata[1:0] == `MODE_DISABLED && !pwdata[`CTRL_FORCE] |-> ##[1:4] !holdoverActive;
  endproperty
  a_leave: assert property (p_leave) else $error("Holdover kept after disable.");
  property p_hold;
    holdoverActive && $past(holdoverActive) && !$past(psel) && !$past(psel, 2)
      && !$past(psel, 3) |-> $stable(dacValue);
  endproperty
  a_hold: assert property (p_hold) else $error("Tuning value moved in holdover.");
endmodule

// >>> loop_partner.sv
`timescale 1ns/1ps
module loop_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic [7:0] errIn1,
  input wire logic [7:0] errIn2,
  output logic busy,
  output logic [1:0] compareToggle,
  output logic [7:0] phaseErrorLoop1,
  output logic [7:0] phaseErrorLoop2
);
  // --------
  // Comparisons every eight cycles, errors steady around each toggle.
  // --------
  logic [2:0] phase;
  logic [7:0] left;
  assign busy = left != 8'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 3'h0;
      left <= 8'h0;
      compareToggle <= 2'h0;
      phaseErrorLoop1 <= 8'h0;
      phaseErrorLoop2 <= 8'h0;
    end else if (start) begin
      phase <= 3'h0;
      left <= count;
      phaseErrorLoop1 <= errIn1;
      phaseErrorLoop2 <= errIn2;
    end else if (busy) begin
      phase <= phase + 3'h1;
      if (phase == 3'h4) begin
        compareToggle <= ~compareToggle;
        left <= left - 8'h1;
      end
    end
  end
endmodule

// >>> holdover_and_lock_detect_ctrl_test.sv
`timescale 1ns/1ps
`include "holdover_ctrl_defs.svh"
module holdover_and_lock_detect_ctrl_test
  import holdover_ctrl_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x;} row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, err, busy, loop1TuneOutputEnable, dacDriveEnable;
  logic lockStatusPin, holdoverStatusPin, loop1LockDetect, loop2LockDetect, holdoverActive;
  logic start = 1'b0;
  logic [7:0] count = 8'h0;
  logic [7:0] e1 = 8'h0;
  logic [7:0] e2 = 8'h0;
  logic [1:0] compareToggle;
  logic [7:0] phaseErrorLoop1, phaseErrorLoop2;
  logic [9:0] tuneLevel = 10'h200;
  logic [9:0] dacValue;
  int failures = 0;
  int nCompared = 0;
  row_t rows [13] = '{
    '{1'b0, `OFS_CTRL, 32'h0, 32'h0001_0000}, '{1'b0, `OFS_MANDAC, 32'h0, 32'h0000_0200},
    '{1'b0, `OFS_TRIP, 32'h0, 32'h03c0_0040}, '{1'b0, `OFS_LOCK1, 32'h0, 32'h0004_0010},
    '{1'b0, `OFS_LOCK2, 32'h0, 32'h0004_0010}, '{1'b0, `OFS_PINSEL, 32'h0, 32'h0000_0052},
    '{1'b0, `OFS_STATUS, 32'h0, 32'h0}, '{1'b0, `OFS_DACCNT, 32'h0, 32'h0},
    '{1'b1, `OFS_DIV1, 32'h3fff_3fff, 32'h3fff_3fff}, '{1'b1, `OFS_DIV2R, 32'h8_0fff, 32'h8_0fff},
    '{1'b1, `OFS_DIV2R, 32'h9_0002, 32'h8_0002}, '{1'b1, `OFS_DIV2N, 32'h3_ffff, 32'h3_ffff},
    '{1'b1, `OFS_CTRL, 32'h0001_0080, 32'h0001_0080}};
  always #10 clk = ~clk;
  holdover_and_lock_detect_ctrl dut_u (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .compareToggle, .phaseErrorLoop1, .phaseErrorLoop2,
    .tuneLevel, .loop1TuneOutputEnable, .dacDriveEnable, .dacValue, .lockStatusPin,
    .holdoverStatusPin, .loop1LockDetect, .loop2LockDetect, .holdoverActive);
  loop_partner far_u (.clk, .resetn, .start, .count, .errIn1(e1), .errIn2(e2), .busy,
    .compareToggle, .phaseErrorLoop1, .phaseErrorLoop2);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic flags(input logic [6:0] exp);
    chk(32'({holdoverActive, loop1LockDetect, loop2LockDetect, loop1TuneOutputEnable,
      dacDriveEnable, lockStatusPin, holdoverStatusPin}), 32'(exp));
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic cmps(input logic [7:0] n, input logic [7:0] a, input logic [7:0] b);
    count <= n;
    e1 <= a;
    e2 <= b;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", nCompared, failures);
    if (failures == 0 && nCompared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].x);
      chk(32'(err), 32'h0);
    end
    apb(1'b1, 8'h2c, 32'h5);
    chk(32'(err), 32'h1);
    apb(1'b0, 8'h2c, 32'h0);
    chk(32'({err, rd[30:0]}), 32'h8000_0000);
    for (int p = 2; p <= 8; p++) begin
      apb(1'b1, `OFS_DIV2R, (32'(p) << 16) | 32'h2);
      apb(1'b0, `OFS_DIV2R, 32'h0);
      chk(rd, (32'(p) << 16) | 32'h2);
    end
    apb(1'b1, `OFS_LOCK1, 32'h0410);
    apb(1'b1, `OFS_LOCK2, 32'h0310);
    cmps(3, 8'h02, 8'h02);
    flags(7'b0011000);
    cmps(1, 8'h20, 8'h02);
    for (int c = 0; c < 6; c++) begin
      apb(1'b1, `OFS_PINSEL, 32'(c * 17));
      chk(32'({lockStatusPin, holdoverStatusPin}),
        (c == 1 || c == 3) ? 32'h3 : 32'h0);
    end
    apb(1'b1, `OFS_PINSEL, 32'({PIN_HOLDOVER, PIN_LOCK1}));
    cmps(3, 8'h02, 8'h02);
    flags(7'b0011000);
    cmps(1, 8'h02, 8'h02);
    flags(7'b0111010);
    cmps(1, 8'h10, 8'h02);
    flags(7'b0011000);
    cmps(4, 8'h02, 8'h02);
    apb(1'b1, `OFS_MANDAC, 32'h155);
    apb(1'b1, `OFS_CTRL, 32'h0001_000a);
    cmps(1, 8'h20, 8'h02);
    flags(7'b1010101);
    chk(32'(dacValue), 32'h155);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(32'(rd[1:0]), 32'h3);
    cmps(4, 8'h02, 8'h02);
    flags(7'b0111010);
    apb(1'b1, `OFS_PINSEL, 32'h44);
    chk(32'({lockStatusPin, holdoverStatusPin}), 32'h3);
    apb(1'b1, `OFS_PINSEL, 32'h52);
    apb(1'b1, `OFS_CTRL, 32'h0001_004a);
    cmps(1, 8'h20, 8'h02);
    flags(7'b0011000);
    cmps(4, 8'h02, 8'h02);
    apb(1'b1, `OFS_CTRL, 32'h0001_0004);
    cmps(4, 8'h02, 8'h02);
    flags(7'b1010101);
    apb(1'b1, `OFS_CTRL, 32'h0001_0000);
    flags(7'b0111010);
    tuneLevel <= 10'h205;
    apb(1'b1, `OFS_CTRL, 32'h0002_0010);
    cmps(4, 8'h02, 8'h02);
    apb(1'b0, `OFS_DACCNT, 32'h0);
    chk(rd, 32'h202);
    apb(1'b1, `OFS_CTRL, 32'h0002_0014);
    cmps(4, 8'h02, 8'h02);
    apb(1'b0, `OFS_DACCNT, 32'h0);
    chk(32'({dacValue, rd[15:0]}), 32'h0202_0202);
    apb(1'b1, `OFS_CTRL, 32'h0002_001c);
    chk(32'(dacValue), 32'h155);
    apb(1'b1, `OFS_CTRL, 32'h0002_0032);
    chk(32'(holdoverActive), 32'h0);
    tuneLevel <= 10'h3d0;
    repeat (8) @(posedge clk);
    chk(32'(holdoverActive), 32'h1);
    apb(1'b1, `OFS_PINSEL, 32'h86);
    chk(32'({lockStatusPin, holdoverStatusPin}), 32'h3);
    apb(1'b1, `OFS_PINSEL, 32'h07);
    chk(32'({lockStatusPin, holdoverStatusPin}), 32'h0);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    flags(7'b0001000);
    chk(32'(dacValue), 32'h200);
    resetn <= 1'b1;
    @(posedge clk);
    apb(1'b0, `OFS_CTRL, 32'h0);
    chk(rd, 32'h0001_0000);
    test_done();
  end
endmodule
bind holdover_and_lock_detect_ctrl holdover_and_lock_detect_ctrl_checker chk_u (.clk, .resetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .loop1TuneOutputEnable, .dacDriveEnable, .dacValue, .loop1LockDetect, .holdoverActive);
